/* pkg/lgb_cfg.svh */
`ifndef LGB_CFG_SVH
`define LGB_CFG_SVH
// register subaddresses
`define LGB_GAMMA_FIRST 6'h26
`define LGB_GAMMA_LAST 6'h33
`define LGB_AVG_BRIGHT 6'h34
// gamma register count and curve size
`define LGB_GAMMA_REGS 14
`define LGB_CURVE_PTS 7
// fixed curve end points
`define LGB_FIX_LO_IN 8'h10
`define LGB_FIX_HI_IN 8'hf0
`define LGB_FIX_MIN 8'h00
`define LGB_FIX_MAX 8'hff
// reset values
`define LGB_GAMMA_RST 8'h00
`define LGB_AVG_RST 8'h00
// pipeline latency of the gamma stage in clock cycles
`define LGB_PIPE_LAT 2
`endif

/* pkg/lgb_pkg.sv */
package lgb_pkg;
	typedef logic [7:0] lgb_byte_t;
	typedef logic [5:0] lgb_addr_t;
	typedef enum logic [1:0] {
		LGB_CURVE_A = 2'b01,
		LGB_CURVE_B = 2'b10
	} lgb_curve_t;
endpackage

/* hdl/lgb_gamma_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lgb_cfg.svh"
// -----------------------------------------
// gamma point register bank
// -----------------------------------------
module lgb_gamma_regs
	import lgb_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic wr_en_i,
	input wire logic [3:0] wr_idx_i,
	input wire lgb_pkg::lgb_byte_t wr_data_i,
	input wire logic [3:0] rd_idx_i,
	output lgb_pkg::lgb_byte_t rd_data_o,
	output logic [111:0] flat_o
);
	lgb_byte_t mem_q [`LGB_GAMMA_REGS];

	always_ff @(posedge ref_clk_i) begin
		for (int i = 0; i < `LGB_GAMMA_REGS; i++) begin
			if (sys_rst_i) begin
				mem_q[i] <= `LGB_GAMMA_RST;
			end else if (wr_en_i && wr_idx_i == 4'(i)) begin
				mem_q[i] <= wr_data_i;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			rd_data_o <= `LGB_GAMMA_RST;
		end else if (rd_idx_i < 4'(`LGB_GAMMA_REGS)) begin
			rd_data_o <= mem_q[rd_idx_i];
		end else begin
			rd_data_o <= `LGB_GAMMA_RST;
		end
	end

	always_comb begin
		for (int i = 0; i < `LGB_GAMMA_REGS; i++) begin
			flat_o[i*8 +: 8] = mem_q[i];
		end
	end
endmodule
`default_nettype wire

/* hdl/lgb_luma_gamma_monitor.sv */
// Overview of operation
// - fourteen byte gamma registers at 26h onward
// - gamma applies to luma, chroma passes through
// - exactly one curve active, never blended
// - breakpoints at 32 through 224, step 32
// - linear interpolation between neighbouring breakpoints
// - points 0,16,240,255 fixed, not writable
// - brightness register at 34h is read only
// - only active video luma is averaged
// - brightness latched on vsync falling edge
// - read returns most recent latched value
`timescale 1ns/1ps
`default_nettype none
`include "lgb_cfg.svh"
module lgb_luma_gamma_monitor
	import lgb_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic pix_valid_i,
	input wire logic pix_is_luma_i,
	input wire lgb_pkg::lgb_byte_t pix_data_i,
	input wire logic active_video_i,
	input wire logic vsync_n_i,
	input wire logic curve_b_sel_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire lgb_pkg::lgb_addr_t register_subaddress_bits_i,
	input wire lgb_pkg::lgb_byte_t reg_wdata_i,
	output lgb_pkg::lgb_byte_t reg_rdata_o,
	output logic reg_rvalid_o,
	output logic pix_valid_o,
	output lgb_pkg::lgb_byte_t pix_data_o,
	output lgb_pkg::lgb_byte_t avg_brightness_o
);
	import lgb_pkg::*;

	// -----------------------------------------
	// functions
	// -----------------------------------------
	function automatic logic in_gamma(input lgb_addr_t a);
		in_gamma = (a >= `LGB_GAMMA_FIRST) && (a <= `LGB_GAMMA_LAST);
	endfunction

	// point value at knot k (0..8 span ends), curve base offset
	function automatic lgb_byte_t knot(input logic [111:0] f, input logic [3:0] k, input logic [3:0] base);
		logic [3:0] ix;
		ix = 4'(base + k - 4'h1);
		if (k == 4'h0) begin
			knot = `LGB_FIX_LO_IN;
		end else if (k == 4'h8) begin
			knot = `LGB_FIX_HI_IN;
		end else begin
			knot = f[ix*8 +: 8];
		end
	endfunction

	// -----------------------------------------
	// register access
	// -----------------------------------------
	logic [111:0] gamma_flat;
	logic [3:0] gidx;
	lgb_byte_t avg_q;
	lgb_curve_t curve_q;

	assign gidx = 4'(register_subaddress_bits_i - `LGB_GAMMA_FIRST);

	lgb_gamma_regs u_regs (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.wr_en_i(reg_wr_i && in_gamma(register_subaddress_bits_i)),
		.wr_idx_i(gidx),
		.wr_data_i(reg_wdata_i),
		.rd_idx_i(gidx),
		.rd_data_o(),
		.flat_o(gamma_flat)
	);

	// read data registered: gamma regs, latched brightness, else zero
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			reg_rvalid_o <= 1'b0;
			reg_rdata_o <= 8'h00;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i && in_gamma(register_subaddress_bits_i)) begin
				reg_rdata_o <= gamma_flat[gidx*8 +: 8];
			end else if (reg_rd_i && register_subaddress_bits_i == `LGB_AVG_BRIGHT) begin
				reg_rdata_o <= avg_q;
			end else begin
				reg_rdata_o <= 8'h00;
			end
		end
	end

	// -----------------------------------------
	// curve selection
	// -----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			curve_q <= LGB_CURVE_A;
		end else begin
			curve_q <= curve_b_sel_i ? LGB_CURVE_B : LGB_CURVE_A;
		end
	end

	// -----------------------------------------
	// gamma stage
	// -----------------------------------------
	logic [3:0] base;
	logic [3:0] seg;
	lgb_byte_t y0, y1;
	logic [8:0] x0, x1;
	logic [8:0] span;
	logic [8:0] frac;
	lgb_byte_t s1_y0_q, s1_y1_q, s1_raw_q;
	logic [8:0] s1_frac_q, s1_span_q;
	logic s1_luma_q, s1_vld_q;
	logic signed [18:0] prod;
	logic signed [9:0] diff;

	always_comb begin
		unique case (curve_q)
			LGB_CURVE_A: base = 4'h0;
			LGB_CURVE_B: base = 4'h7;
			default: base = 4'h0;
		endcase
	end

	// segment edges: 0,16,32..224,240,255
	always_comb begin
		seg = 4'h0;
		x0 = 9'h000;
		x1 = 9'h010;
		y0 = `LGB_FIX_MIN;
		y1 = `LGB_FIX_LO_IN;
		if (pix_data_i < `LGB_FIX_LO_IN) begin
			x0 = 9'h000;
			x1 = 9'h010;
			y0 = `LGB_FIX_MIN;
			y1 = `LGB_FIX_LO_IN;
		end else if (pix_data_i >= `LGB_FIX_HI_IN) begin
			x0 = 9'h0f0;
			x1 = 9'h0ff;
			y0 = `LGB_FIX_HI_IN;
			y1 = `LGB_FIX_MAX;
		end else if (pix_data_i < 8'h20) begin
			x0 = 9'h010;
			x1 = 9'h020;
			y0 = `LGB_FIX_LO_IN;
			y1 = knot(gamma_flat, 4'h1, base);
		end else if (pix_data_i >= 8'he0) begin
			x0 = 9'h0e0;
			x1 = 9'h0f0;
			y0 = knot(gamma_flat, 4'h7, base);
			y1 = `LGB_FIX_HI_IN;
		end else begin
			seg = 4'(pix_data_i[7:5]);
			x0 = {1'b0, pix_data_i[7:5], 5'h00};
			x1 = 9'(x0 + 9'h020);
			y0 = knot(gamma_flat, seg, base);
			y1 = knot(gamma_flat, 4'(seg + 4'h1), base);
		end
		span = 9'(x1 - x0);
		frac = 9'({1'b0, pix_data_i} - x0);
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			s1_y0_q <= 8'h00;
			s1_y1_q <= 8'h00;
			s1_raw_q <= 8'h00;
			s1_frac_q <= 9'h000;
			s1_span_q <= 9'h010;
			s1_luma_q <= 1'b0;
			s1_vld_q <= 1'b0;
		end else begin
			s1_y0_q <= y0;
			s1_y1_q <= y1;
			s1_raw_q <= pix_data_i;
			s1_frac_q <= frac;
			s1_span_q <= span;
			s1_luma_q <= pix_is_luma_i;
			s1_vld_q <= pix_valid_i;
		end
	end

	assign diff = 10'($signed({2'b00, s1_y1_q}) - $signed({2'b00, s1_y0_q}));
	// widen before the product so the slope times offset cannot wrap
	assign prod = 19'(diff) * $signed({10'h000, s1_frac_q});

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			pix_valid_o <= 1'b0;
			pix_data_o <= 8'h00;
		end else begin
			pix_valid_o <= s1_vld_q;
			if (s1_luma_q) begin
				pix_data_o <= 8'($signed({11'd0, s1_y0_q}) + prod / $signed({10'd0, s1_span_q}));
			end else begin
				pix_data_o <= s1_raw_q;
			end
		end
	end

	// -----------------------------------------
	// brightness monitor
	// -----------------------------------------
	logic [31:0] sum_q;
	logic [23:0] cnt_q;
	logic vs_q;

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			vs_q <= 1'b1;
		end else begin
			vs_q <= vsync_n_i;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			sum_q <= 32'h0;
			cnt_q <= 24'h0;
			avg_q <= `LGB_AVG_RST;
		end else if (vs_q && !vsync_n_i) begin
			avg_q <= (cnt_q == 24'h0) ? 8'h00 : 8'(sum_q / {8'h00, cnt_q});
			sum_q <= 32'h0;
			cnt_q <= 24'h0;
		end else if (pix_valid_i && pix_is_luma_i && active_video_i) begin
			sum_q <= 32'(sum_q + {24'h0, pix_data_i});
			cnt_q <= 24'(cnt_q + 24'h1);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			avg_brightness_o <= `LGB_AVG_RST;
		end else begin
			avg_brightness_o <= avg_q;
		end
	end
endmodule
`default_nettype wire

/* test/lgb_chk_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// --
// port checker
// --
module lgb_chk
	import lgb_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic pix_valid_i,
	input wire logic pix_is_luma_i,
	input wire lgb_pkg::lgb_byte_t pix_data_i,
	input wire logic vsync_n_i,
	input wire logic reg_rd_i,
	input wire lgb_pkg::lgb_addr_t register_subaddress_bits_i,
	input wire lgb_pkg::lgb_byte_t reg_rdata_o,
	input wire logic reg_rvalid_o,
	input wire logic pix_valid_o,
	input wire lgb_pkg::lgb_byte_t pix_data_o,
	input wire lgb_pkg::lgb_byte_t avg_brightness_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	logic vs_q;
	logic [3:0] fell_q;
	always_ff @(posedge ref_clk_i) begin
		vs_q <= vsync_n_i;
		fell_q <= {fell_q[2:0], vs_q & ~vsync_n_i};
	end
	chk_rd_answer: assert property (reg_rd_i |=> reg_rvalid_o) else $error("read unanswered");
	chk_rvalid_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i)) else $error("stray answer");
	chk_valid_fwd: assert property (pix_valid_i |-> ##2 pix_valid_o) else $error("sample lost");
	chk_valid_idle: assert property (!pix_valid_i |-> ##2 !pix_valid_o) else $error("stray sample");
	chk_chroma_pass: assert property (pix_valid_i && !pix_is_luma_i |->
		##2 pix_data_o == $past(pix_data_i, 2)) else $error("chroma altered");
	chk_fixed_pts: assert property (pix_valid_i && pix_is_luma_i &&
		pix_data_i inside {8'h00, 8'h10, 8'hf0, 8'hff} |-> ##2 pix_data_o == $past(pix_data_i, 2))
		else $error("fixed point moved");
	chk_avg_hold: assert property ($changed(avg_brightness_o) |-> |fell_q) else $error("avg off field");
	chk_unmapped_zero: assert property (reg_rd_i && register_subaddress_bits_i > 6'h34 |=>
		reg_rdata_o == 8'h00) else $error("unmapped not zero");
	chk_avg_read: assert property (reg_rd_i && register_subaddress_bits_i == 6'h34 |=>
		reg_rdata_o == avg_brightness_o) else $error("brightness read differs");
	cov_read: cover property (reg_rvalid_o);
	cov_fall: cover property (fell_q[0]);
	cov_luma: cover property (pix_valid_o && pix_data_o != 8'h00);
endmodule
bind lgb_luma_gamma_monitor lgb_chk u_chk (.ref_clk_i, .sys_rst_i, .pix_valid_i, .pix_is_luma_i, .pix_data_i,
	.vsync_n_i, .reg_rd_i, .register_subaddress_bits_i, .reg_rdata_o, .reg_rvalid_o, .pix_valid_o, .pix_data_o,
	.avg_brightness_o);
`default_nettype wire

/* test/lgb_src.sv */
`timescale 1ns/1ps
`default_nettype none
// --
// upstream video source
// --
module lgb_src
	import lgb_pkg::*;
(
	input wire logic ref_clk_i,
	output logic pix_valid_o = 1'b0,
	output logic pix_is_luma_o = 1'b0,
	output lgb_pkg::lgb_byte_t pix_data_o = 8'h00,
	output logic active_video_o = 1'b0,
	output logic vsync_n_o = 1'b1
);
	// one sample for one cycle, then data shows the inverse
	task automatic put(input logic luma, input logic act, input lgb_byte_t d);
		@(posedge ref_clk_i);
		pix_valid_o <= 1'b1;
		pix_is_luma_o <= luma;
		active_video_o <= act;
		pix_data_o <= d;
		@(posedge ref_clk_i);
		pix_valid_o <= 1'b0;
		pix_data_o <= ~d;
	endtask
	task automatic vsync();
		@(posedge ref_clk_i);
		vsync_n_o <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		vsync_n_o <= 1'b1;
	endtask
endmodule
`default_nettype wire

/* test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin miscompares++; \
	$display("wrong value %s expected %h seen %h", n, e, s); end end
module testbench;
	import lgb_pkg::*;
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic curve_b_sel_i = 1'b0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	lgb_addr_t addr = 6'h00;
	lgb_byte_t wdata = 8'h00;
	lgb_byte_t rdata, pdata, avg, data;
	logic rvalid, pvalid, valid, luma, act, vs_n;
	int miscompares = 0;
	int samples_checked = 0;
	lgb_byte_t pts [0:13];
	initial forever #2.5 ref_clk_i = ~ref_clk_i;
	lgb_src src (.ref_clk_i, .pix_valid_o(valid), .pix_is_luma_o(luma), .pix_data_o(data),
		.active_video_o(act), .vsync_n_o(vs_n));
	lgb_luma_gamma_monitor uut (.ref_clk_i, .sys_rst_i, .pix_valid_i(valid), .pix_is_luma_i(luma),
		.pix_data_i(data), .active_video_i(act), .vsync_n_i(vs_n), .curve_b_sel_i, .reg_wr_i, .reg_rd_i,
		.register_subaddress_bits_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
		.pix_valid_o(pvalid), .pix_data_o(pdata), .avg_brightness_o(avg));
	task automatic final_report();
		$display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic wr(input lgb_addr_t a, input lgb_byte_t d);
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input lgb_addr_t a, input lgb_byte_t e);
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b1;
		addr <= a;
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b0;
		#1 `CHK("rvalid", 1'b1, rvalid)
		`CHK("rdata", e, rdata)
	endtask
	// gamma out: b selects curve base, ends and fixed points pass through
	function automatic lgb_byte_t gam(input int x, input int b);
		int i, x0, x1, y0, y1;
		if (x < 16 || x >= 240) return lgb_byte_t'(x);
		i = x / 32;
		x0 = (i == 0) ? 16 : 32 * i;
		x1 = (i == 7) ? 240 : 32 * i + 32;
		y0 = (i == 0) ? 16 : pts[b + i - 1];
		y1 = (i == 7) ? 240 : pts[b + i];
		return lgb_byte_t'(y0 + (y1 - y0) * (x - x0) / (x1 - x0));
	endfunction
	task automatic px(input logic l, input lgb_byte_t d, input lgb_byte_t e);
		src.put(l, 1'b1, d);
		@(posedge ref_clk_i);
		#1 `CHK("pix_valid", 1'b1, pvalid)
		`CHK("pix_data", e, pdata)
	endtask
	task automatic t_regs();
		for (int i = 0; i < 14; i++) begin
			pts[i] = (i < 7) ? 8'h20 + 8'(i * 12) : 8'he0 - 8'(i * 12);
			wr(6'h26 + 6'(i), pts[i]);
		end
		for (int i = 0; i < 14; i++) rd(6'h26 + 6'(i), pts[i]);
		rd(6'h3f, 8'h00);
		$display("regs test done");
	endtask
	task automatic t_gamma();
		for (int c = 0; c < 2; c++) begin
			@(posedge ref_clk_i);
			curve_b_sel_i <= c[0];
			for (int x = 0; x < 256; x += 8) px(1'b1, 8'(x), gam(x, 7 * c));
			px(1'b1, 8'hff, 8'hff);
			px(1'b0, 8'h5a, 8'h5a);
		end
		$display("gamma test done");
	endtask
	task automatic t_bright();
		src.vsync();
		for (int i = 1; i < 5; i++) src.put(1'b1, 1'b1, 8'(i * 11));
		src.put(1'b1, 1'b0, 8'hc8);
		src.put(1'b0, 1'b1, 8'hfa);
		src.vsync();
		repeat (4) @(posedge ref_clk_i);
		rd(6'h34, 8'h1b);
		wr(6'h34, 8'hff);
		rd(6'h34, 8'h1b);
		`CHK("avg", 8'h1b, avg)
		src.vsync();
		repeat (4) @(posedge ref_clk_i);
		rd(6'h34, 8'h00);
		$display("brightness test done");
	endtask
	initial begin
		repeat (6) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		t_regs();
		t_gamma();
		t_bright();
		final_report();
	end
endmodule
`default_nettype wire
